//--- src/apc_cfg.svh
// Register map, field positions, reset values and codes of the analog control block
`ifndef APC_CFG_SVH
`define APC_CFG_SVH
`define APC_OFS_CONV_CTRL 5'h00
`define APC_OFS_CONV_STAT 5'h04
`define APC_OFS_CONV_DATA 5'h08
`define APC_OFS_CMP_CTRL 5'h0c
`define APC_OFS_CMP_STAT 5'h10
`define APC_OFS_DAC_CTRL 5'h14
`define APC_OFS_DAC0 5'h18
`define APC_OFS_DAC1 5'h1c
`define APC_CC_START 0
`define APC_CC_CH 1
`define APC_CC_GAIN 4
`define APC_CC_SD 6
`define APC_CC_REF 7
`define APC_CC_SRC 8
`define APC_CC_SYNC 10
`define APC_CC_IE 11
`define APC_CS_FLAG 0
`define APC_CS_BUSY 1
`define APC_CS_PEND 2
`define APC_CMP_STRIDE 8
`define APC_CMP_SD 0
`define APC_CMP_HYST 1
`define APC_CMP_EDGE 3
`define APC_CMP_ROUTE 5
`define APC_CMPS_LVL 0
`define APC_CMPS_FLAG 8
`define APC_DAC_STRIDE 4
`define APC_DAC_SD 0
`define APC_DAC_SRC 1
`define APC_EDGE_RISE 0
`define APC_EDGE_FALL 1
`define APC_TMR_A 0
`define APC_TMR_B 1
`define APC_TMR_C 2
`define APC_SD_RST 1'b1
`endif

//--- src/apc_pkg.sv
// Types shared by the analog control block
package apc_pkg;
	typedef enum logic [1:0] {APC_SRC_SW = 2'b00, APC_SRC_TA = 2'b01, APC_SRC_TB = 2'b10,
		APC_SRC_EXT = 2'b11} apc_src_t;
	typedef enum logic [1:0] {APC_GAIN_HALF = 2'b00, APC_GAIN_1 = 2'b01, APC_GAIN_2 = 2'b10,
		APC_GAIN_4 = 2'b11} apc_gain_t;
	typedef enum logic [1:0] {APC_DSRC_SW = 2'b00, APC_DSRC_T2 = 2'b01, APC_DSRC_T3 = 2'b10,
		APC_DSRC_T4 = 2'b11} apc_dsrc_t;
	typedef enum logic {APC_IDLE = 1'b0, APC_BUSY = 1'b1} apc_state_t;
	typedef struct packed {
		logic shutdown;
		logic ref_ext;
		apc_gain_t gain;
		logic [2:0] channel;
	} apc_conv_cfg_t;
	typedef struct packed {
		logic shutdown;
		logic [1:0] hyst;
		logic [1:0] edge_sel;
		logic route;
	} apc_cmp_cfg_t;
endpackage

//--- src/apc_edge_sync.sv
// Two-flop synchroniser with registered edge pulses for one asynchronous input
`timescale 1ns/10ps
module apc_edge_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic level_q,
	output logic rise_q,
	output logic fall_q
);
	logic meta_q;
	logic sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	// Level and edge pulses from the settled stage
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			level_q <= sync_q;
			rise_q <= sync_q & ~level_q;
			fall_q <= ~sync_q & level_q;
		end
	end
endmodule

//--- src/apc_top.sv
// Control logic for the fast converter, two comparators and two DACs
// Overview of operation
// - Fast converter starts on software, selected timer overflow or external input.
// - With sync enabled, start alongside each precision converter software start.
// - Completion sets a status flag; interrupt only when enabled.
// - 8-bit result captured into a readable register at completion.
// - Gain choice is exactly one of 0.5, 1, 2 or 4.
// - Software shutdown puts the fast converter into power saving.
// - Reference select chooses analog supply or external reference pin.
// - Channel select picks one of eight external inputs.
// - Two 12-bit DACs and two comparators, each with own fields in shared control registers; each DAC has its own data register.
// - Each DAC and comparator has its own shutdown control.
// - Each comparator has programmable hysteresis.
// - Comparator interrupt on rising, falling or both edges as selected.
// - Comparator edge detection keeps running while the processor sleeps.
// - Comparator output state is readable as a status bit.
// - Comparator outputs are offered to the pin routing network.
// - DAC updates on software write or timer 2, 3 or 4 overflow.
`timescale 1ns/10ps
`include "apc_cfg.svh"
module apc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [2:0] tmr_ovf,
	input wire logic prec_sw_start,
	input wire logic ext_start_pin,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [7:0] conv_data,
	output apc_pkg::apc_conv_cfg_t conv_cfg,
	output logic conv_irq,
	input wire logic [1:0] cmp_raw,
	output apc_pkg::apc_cmp_cfg_t [1:0] cmp_cfg,
	output logic [1:0] cmp_route_out,
	output logic cmp_irq,
	output logic [1:0][11:0] dac_out,
	output logic [1:0] dac_shutdown
);
	import apc_pkg::*;

	logic wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	logic acc_wr;
	apc_conv_cfg_t ccfg_q;
	apc_src_t src_q;
	logic sync_q;
	logic ie_q;
	apc_state_t state_q;
	logic start_q;
	logic pend_q;
	logic flag_q;
	logic irq_q;
	logic [7:0] result_q;
	logic sw_go;
	logic start_req;
	logic flag_clr;
	logic conv_fin;
	logic ext_rise;
	apc_cmp_cfg_t [1:0] mcfg_q;
	logic [1:0] cmp_lvl;
	logic [1:0] cmp_rise;
	logic [1:0] cmp_fall;
	logic [1:0] cmp_flag_q;
	logic [1:0] route_q;
	logic cmp_irq_q;
	apc_dsrc_t [1:0] dsrc_q;
	logic [1:0] dsd_q;
	logic [1:0][11:0] stage_q;
	logic [1:0][11:0] dout_q;

	// Bus handshake: one wait cycle, then the access completes
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			wait_q <= 1'b1;
		else
			wait_q <= ~((avs_read | avs_write) & wait_q);
	end

	assign acc_wr = avs_write & ~wait_q;

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_mux = 32'h0;
		case (avs_address)
			`APC_OFS_CONV_CTRL:
			begin
				rd_mux[`APC_CC_CH +: 3] = ccfg_q.channel;
				rd_mux[`APC_CC_GAIN +: 2] = ccfg_q.gain;
				rd_mux[`APC_CC_SD] = ccfg_q.shutdown;
				rd_mux[`APC_CC_REF] = ccfg_q.ref_ext;
				rd_mux[`APC_CC_SRC +: 2] = src_q;
				rd_mux[`APC_CC_SYNC] = sync_q;
				rd_mux[`APC_CC_IE] = ie_q;
			end
			`APC_OFS_CONV_STAT:
			begin
				rd_mux[`APC_CS_FLAG] = flag_q;
				rd_mux[`APC_CS_BUSY] = state_q;
				rd_mux[`APC_CS_PEND] = pend_q;
			end
			`APC_OFS_CONV_DATA: rd_mux[7:0] = result_q;
			`APC_OFS_CMP_CTRL:
			begin
				for (int i = 0; i < 2; i++)
				begin
					rd_mux[`APC_CMP_STRIDE*i + `APC_CMP_SD] = mcfg_q[i].shutdown;
					rd_mux[`APC_CMP_STRIDE*i + `APC_CMP_HYST +: 2] = mcfg_q[i].hyst;
					rd_mux[`APC_CMP_STRIDE*i + `APC_CMP_EDGE +: 2] = mcfg_q[i].edge_sel;
					rd_mux[`APC_CMP_STRIDE*i + `APC_CMP_ROUTE] = mcfg_q[i].route;
				end
			end
			`APC_OFS_CMP_STAT:
			begin
				rd_mux[`APC_CMPS_LVL +: 2] = cmp_lvl & ~{mcfg_q[1].shutdown, mcfg_q[0].shutdown};
				rd_mux[`APC_CMPS_FLAG +: 2] = cmp_flag_q;
			end
			`APC_OFS_DAC_CTRL:
			begin
				rd_mux[`APC_DAC_SD] = dsd_q[0];
				rd_mux[`APC_DAC_SRC +: 2] = dsrc_q[0];
				rd_mux[`APC_DAC_STRIDE + `APC_DAC_SD] = dsd_q[1];
				rd_mux[`APC_DAC_STRIDE + `APC_DAC_SRC +: 2] = dsrc_q[1];
			end
			`APC_OFS_DAC0: rd_mux[11:0] = stage_q[0];
			`APC_OFS_DAC1: rd_mux[11:0] = stage_q[1];
			default: rd_mux = 32'h0;
		endcase
	end

	// Read data registered in the wait cycle, standing when waitrequest falls
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_q <= 32'h0;
		else if (avs_read & wait_q)
			rdata_q <= rd_mux;
	end

	// Fast converter configuration register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ccfg_q <= '{shutdown: `APC_SD_RST, ref_ext: 1'b0, gain: APC_GAIN_1, channel: 3'h0};
			src_q <= APC_SRC_SW;
			sync_q <= 1'b0;
			ie_q <= 1'b0;
		end
		else if (acc_wr && avs_address == `APC_OFS_CONV_CTRL)
		begin
			ccfg_q.channel <= avs_writedata[`APC_CC_CH +: 3];
			ccfg_q.gain <= apc_gain_t'(avs_writedata[`APC_CC_GAIN +: 2]);
			ccfg_q.shutdown <= avs_writedata[`APC_CC_SD];
			ccfg_q.ref_ext <= avs_writedata[`APC_CC_REF];
			src_q <= apc_src_t'(avs_writedata[`APC_CC_SRC +: 2]);
			sync_q <= avs_writedata[`APC_CC_SYNC];
			ie_q <= avs_writedata[`APC_CC_IE];
		end
	end

	// External start pin synchronised before use
	apc_edge_sync u_ext_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(ext_start_pin),
		.level_q(),
		.rise_q(ext_rise),
		.fall_q()
	);

	// Start source selection
	assign sw_go = acc_wr && avs_address == `APC_OFS_CONV_CTRL && avs_writedata[`APC_CC_START];
	assign start_req = ~ccfg_q.shutdown & (sw_go
		| (src_q == APC_SRC_TA & tmr_ovf[`APC_TMR_A])
		| (src_q == APC_SRC_TB & tmr_ovf[`APC_TMR_B])
		| (src_q == APC_SRC_EXT & ext_rise)
		| (sync_q & prec_sw_start));
	assign conv_fin = state_q == APC_BUSY && conv_done;

	// Conversion sequencer with one pending start
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= APC_IDLE;
			start_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else if (ccfg_q.shutdown)
		begin
			state_q <= APC_IDLE;
			start_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			start_q <= 1'b0;
			case (state_q)
				APC_IDLE:
				begin
					if (start_req | pend_q)
					begin
						start_q <= 1'b1;
						pend_q <= 1'b0;
						state_q <= APC_BUSY;
					end
				end
				APC_BUSY:
				begin
					if (start_req)
						pend_q <= 1'b1;
					if (conv_done)
						state_q <= APC_IDLE;
				end
				default: state_q <= APC_IDLE;
			endcase
		end
	end

	// Completion flag: set wins over clear
	assign flag_clr = acc_wr && avs_address == `APC_OFS_CONV_STAT && avs_writedata[`APC_CS_FLAG];
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			flag_q <= 1'b0;
		else if (conv_fin)
			flag_q <= 1'b1;
		else if (flag_clr)
			flag_q <= 1'b0;
	end

	// Result latch and gated interrupt
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			result_q <= 8'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			if (conv_fin)
				result_q <= conv_data;
			irq_q <= flag_q & ie_q;
		end
	end

	// Comparator configuration register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mcfg_q[0] <= '{shutdown: `APC_SD_RST, hyst: 2'h0, edge_sel: 2'h0, route: 1'b0};
			mcfg_q[1] <= '{shutdown: `APC_SD_RST, hyst: 2'h0, edge_sel: 2'h0, route: 1'b0};
		end
		else if (acc_wr && avs_address == `APC_OFS_CMP_CTRL)
		begin
			// Fields unpacked by their named positions, one comparator per stride
			for (int i = 0; i < 2; i++)
			begin
				mcfg_q[i].shutdown <= avs_writedata[`APC_CMP_STRIDE*i + `APC_CMP_SD];
				mcfg_q[i].hyst <= avs_writedata[`APC_CMP_STRIDE*i + `APC_CMP_HYST +: 2];
				mcfg_q[i].edge_sel <= avs_writedata[`APC_CMP_STRIDE*i + `APC_CMP_EDGE +: 2];
				mcfg_q[i].route <= avs_writedata[`APC_CMP_STRIDE*i + `APC_CMP_ROUTE];
			end
		end
	end

	// Per comparator: sync, edge flags and pin routing on the free-running clock
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cmp
			apc_edge_sync u_cmp_sync (
				.clk(clk),
				.rst_n(rst_n),
				.async_in(cmp_raw[gi]),
				.level_q(cmp_lvl[gi]),
				.rise_q(cmp_rise[gi]),
				.fall_q(cmp_fall[gi])
			);
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					cmp_flag_q[gi] <= 1'b0;
				else if (~mcfg_q[gi].shutdown
					& ((mcfg_q[gi].edge_sel[`APC_EDGE_RISE] & cmp_rise[gi])
					| (mcfg_q[gi].edge_sel[`APC_EDGE_FALL] & cmp_fall[gi])))
					cmp_flag_q[gi] <= 1'b1;
				else if (acc_wr && avs_address == `APC_OFS_CMP_STAT
					&& avs_writedata[`APC_CMPS_FLAG + gi])
					cmp_flag_q[gi] <= 1'b0;
			end
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					route_q[gi] <= 1'b0;
				else
					route_q[gi] <= mcfg_q[gi].route & ~mcfg_q[gi].shutdown & cmp_lvl[gi];
			end
		end
	endgenerate

	// Comparator interrupt doubles as the wake request
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cmp_irq_q <= 1'b0;
		else
			cmp_irq_q <= |cmp_flag_q;
	end

	// DAC control register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dsd_q <= {2{`APC_SD_RST}};
			dsrc_q[0] <= APC_DSRC_SW;
			dsrc_q[1] <= APC_DSRC_SW;
		end
		else if (acc_wr && avs_address == `APC_OFS_DAC_CTRL)
		begin
			dsd_q[0] <= avs_writedata[`APC_DAC_SD];
			dsd_q[1] <= avs_writedata[`APC_DAC_STRIDE + `APC_DAC_SD];
			dsrc_q[0] <= apc_dsrc_t'(avs_writedata[`APC_DAC_SRC +: 2]);
			dsrc_q[1] <= apc_dsrc_t'(avs_writedata[`APC_DAC_STRIDE + `APC_DAC_SRC +: 2]);
		end
	end

	// Per DAC: staging register and scheduled output update
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_dac
			logic dwr;
			logic tick;
			assign dwr = acc_wr && avs_address == (gi == 0 ? `APC_OFS_DAC0 : `APC_OFS_DAC1);
			assign tick = (dsrc_q[gi] == APC_DSRC_T2 & tmr_ovf[`APC_TMR_A])
				| (dsrc_q[gi] == APC_DSRC_T3 & tmr_ovf[`APC_TMR_B])
				| (dsrc_q[gi] == APC_DSRC_T4 & tmr_ovf[`APC_TMR_C]);
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					stage_q[gi] <= 12'h0;
				else if (dwr)
					stage_q[gi] <= avs_writedata[11:0];
			end
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					dout_q[gi] <= 12'h0;
				else if (dsrc_q[gi] == APC_DSRC_SW && dwr)
					dout_q[gi] <= avs_writedata[11:0];
				else if (tick)
					dout_q[gi] <= stage_q[gi];
			end
		end
	endgenerate

	// Outputs straight from flops
	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;
	assign conv_start = start_q;
	assign conv_cfg = ccfg_q;
	assign conv_irq = irq_q;
	assign cmp_cfg = mcfg_q;
	assign cmp_route_out = route_q;
	assign cmp_irq = cmp_irq_q;
	assign dac_out = dout_q;
	assign dac_shutdown = dsd_q;

	// Checks on the converter, comparator and DAC paths
	a_sw_start_conv: assert property (@(posedge clk) disable iff (!rst_n)
		sw_go && !ccfg_q.shutdown && state_q == APC_IDLE |=> conv_start && state_q == APC_BUSY)
		else $error("software start did not start a conversion");
	a_timer_start: assert property (@(posedge clk) disable iff (!rst_n)
		!ccfg_q.shutdown && state_q == APC_IDLE && src_q == APC_SRC_TB && tmr_ovf[`APC_TMR_B]
		|=> conv_start)
		else $error("timer overflow did not start a conversion");
	a_sync_start: assert property (@(posedge clk) disable iff (!rst_n)
		!ccfg_q.shutdown && sync_q && prec_sw_start && state_q == APC_IDLE |=> conv_start)
		else $error("synchronised start missing");
	a_done_flag: assert property (@(posedge clk) disable iff (!rst_n)
		conv_fin |=> flag_q ##1 (conv_irq == $past(ie_q)))
		else $error("completion flag or interrupt wrong");
	a_irq_gated: assert property (@(posedge clk) disable iff (!rst_n)
		!ie_q ##1 !ie_q |-> !conv_irq)
		else $error("interrupt raised while disabled");
	a_result_latch: assert property (@(posedge clk) disable iff (!rst_n)
		conv_fin |=> result_q == $past(conv_data))
		else $error("result not captured at completion");
	a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		flag_q && !flag_clr |=> flag_q)
		else $error("completion flag dropped without clear");
	a_start_kept: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == APC_BUSY && start_req && conv_done && !sw_go ##1 !ccfg_q.shutdown
		|=> conv_start)
		else $error("start during busy conversion lost");
	a_cmp_edge: assert property (@(posedge clk) disable iff (!rst_n)
		!mcfg_q[1].shutdown && mcfg_q[1].edge_sel[`APC_EDGE_FALL] && cmp_fall[1]
		|=> cmp_flag_q[1] ##1 cmp_irq)
		else $error("selected comparator edge not flagged");
	a_dac_sw: assert property (@(posedge clk) disable iff (!rst_n)
		g_dac[0].dwr && dsrc_q[0] == APC_DSRC_SW |=> dac_out[0] == $past(avs_writedata[11:0]))
		else $error("software DAC write not applied");
	a_dac_hold: assert property (@(posedge clk) disable iff (!rst_n)
		dsrc_q[1] != APC_DSRC_SW && !g_dac[1].tick |=> $stable(dac_out[1]))
		else $error("timer-mode DAC changed without overflow");
	c_conv_done: cover property (@(posedge clk) disable iff (!rst_n) conv_fin && ie_q);
	c_cmp_both: cover property (@(posedge clk) disable iff (!rst_n)
		cmp_rise[1] && mcfg_q[1].edge_sel == 2'h3);
	c_dac_timer: cover property (@(posedge clk) disable iff (!rst_n)
		g_dac[0].tick && dsrc_q[0] == APC_DSRC_T4);
endmodule

//--- dv/apc_conv_model.sv
// Behavioural analog front end of the fast converter
`timescale 1ns/10ps
module apc_conv_model (
	input wire logic clk,
	input wire logic conv_start,
	input wire logic [7:0] lat,
	output logic conv_done,
	output logic [7:0] conv_data,
	output logic [7:0] last_q
);
	int cnt = 0;
	initial conv_done = 1'b0;
	initial conv_data = 8'h5a;
	initial last_q = 8'h00;
	// Counts the conversion time after each start, then pulses done with a new code
	always @(posedge clk)
	begin
		conv_done <= 1'b0;
		conv_data <= ~conv_data; // Result lines are not held outside the done cycle
		if (cnt == 1)
		begin
			conv_done <= 1'b1;
			conv_data <= last_q + 8'h37;
			last_q <= last_q + 8'h37;
		end
		if (conv_start)
			cnt <= int'(lat);
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule

//--- dv/apc_top_tb_top.sv
// Self-checking bench for the analog control block
`timescale 1ns/10ps
module apc_top_tb_top;
	import apc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, conv_start, conv_done, conv_irq, cmp_irq;
	logic [2:0] tmr_ovf = 3'h0;
	logic prec_sw_start = 1'b0;
	logic ext_start_pin = 1'b0;
	logic [7:0] conv_data, last_code;
	logic [7:0] lat = 8'h03;
	logic [1:0] cmp_raw = 2'h0;
	logic [1:0] cmp_route_out, dac_shutdown;
	logic [1:0][11:0] dac_out;
	apc_conv_cfg_t conv_cfg;
	apc_cmp_cfg_t [1:0] cmp_cfg;
	int n_fail = 0;
	int tests_run = 0;
	int n_starts = 0;
	int n0;

	apc_top u_apc_top (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .tmr_ovf, .prec_sw_start, .ext_start_pin, .conv_start,
		.conv_done, .conv_data, .conv_cfg, .conv_irq, .cmp_raw, .cmp_cfg, .cmp_route_out,
		.cmp_irq, .dac_out, .dac_shutdown);
	apc_conv_model u_apc_conv_model (.clk, .conv_start, .lat, .conv_done, .conv_data,
		.last_q(last_code));

	// Clock and start counter
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (conv_start === 1'b1) n_starts++;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int t = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && t < 50)
		begin
			@(posedge clk);
			t++;
		end
		if (t >= 50) n_fail++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic pulse_tmr(input logic [2:0] m);
		tmr_ovf <= m;
		@(posedge clk);
		tmr_ovf <= 3'h0;
		cyc(int'(lat) + 6);
	endtask

	// Reset state of outputs, plus an unmapped read
	task automatic t_reset;
		chk("conv_cfg", 32'h48, conv_cfg);
		chk("dac_sd", 32'h3, dac_shutdown);
		chk("cmp_cfg", 32'h820, {cmp_cfg[1], cmp_cfg[0]});
		bus(1'b0, 5'h03, 32'h0);
		chk("unmapped", 32'h0, q);
	endtask

	// Software starts with every gain; flag, irq, result and clear
	task automatic t_conv_sw;
		logic [1:0] g;
		logic [2:0] ch;
		bus(1'b1, 5'h00, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			g = i[1:0];
			ch = 3'(i + 3);
			n0 = n_starts;
			bus(1'b1, 5'h00, {20'h0, g != 2'b00, 3'b000, g[0], 1'b0, g, ch, 1'b1});
			cyc(int'(lat) + 6);
			chk("cfg", {25'h0, 1'b0, g[0], g, ch}, conv_cfg);
			chk("starts", 32'(n0 + 1), 32'(n_starts));
			chk("irq", {31'h0, g != 2'b00}, conv_irq);
			bus(1'b0, 5'h04, 32'h0);
			chk("flag", 32'h1, q[0]);
			bus(1'b0, 5'h08, 32'h0);
			chk("result", last_code, q[7:0]);
			bus(1'b1, 5'h04, 32'h1);
			cyc(2);
			chk("irq_clr", 32'h0, conv_irq);
		end
	endtask

	// Start while busy is kept and issued afterwards
	task automatic t_busy;
		lat <= 8'd20;
		n0 = n_starts;
		bus(1'b1, 5'h00, 32'h1);
		bus(1'b1, 5'h00, 32'h1);
		cyc(60);
		chk("pend", 32'(n0 + 2), 32'(n_starts));
		lat <= 8'd3;
		bus(1'b1, 5'h04, 32'h1);
	endtask

	// Timer, external and synchronised start sources, and shutdown
	task automatic t_sources;
		for (int s = 1; s < 4; s++)
		begin
			bus(1'b1, 5'h00, 32'(s << 8));
			n0 = n_starts;
			pulse_tmr((s == 1) ? 3'b010 : 3'b001);
			chk("no_start", 32'(n0), 32'(n_starts));
			if (s == 3)
			begin
				ext_start_pin <= 1'b1;
				cyc(5);
				ext_start_pin <= 1'b0;
				cyc(int'(lat) + 6);
			end
			else
				pulse_tmr(3'(s));
			chk("src_start", 32'(n0 + 1), 32'(n_starts));
		end
		bus(1'b1, 5'h00, 32'h400);
		n0 = n_starts;
		prec_sw_start <= 1'b1;
		@(posedge clk);
		prec_sw_start <= 1'b0;
		cyc(int'(lat) + 6);
		chk("sync", 32'(n0 + 1), 32'(n_starts));
		bus(1'b1, 5'h00, 32'h40);
		n0 = n_starts;
		bus(1'b1, 5'h00, 32'h41);
		cyc(int'(lat) + 6);
		chk("sd_start", 32'(n0), 32'(n_starts));
		chk("sd_cfg", 32'h1, conv_cfg.shutdown);
		bus(1'b1, 5'h04, 32'h1);
	endtask

	// Comparator settings, edges, status and routing
	task automatic t_cmp;
		bus(1'b1, 5'h0c, 32'h122c);
		cyc(2);
		chk("cmp0", 32'h13, cmp_cfg[0]);
		chk("cmp1", 32'h0c, cmp_cfg[1]);
		cmp_raw <= 2'b11;
		cyc(8);
		chk("cmp_irq", 32'h1, cmp_irq);
		chk("route", 32'h1, cmp_route_out);
		bus(1'b0, 5'h10, 32'h0);
		chk("cmp_stat", 32'h103, q[9:0]);
		bus(1'b1, 5'h10, 32'h300);
		cyc(2);
		chk("cmp_clr", 32'h0, cmp_irq);
		cmp_raw <= 2'b00;
		cyc(8);
		bus(1'b0, 5'h10, 32'h0);
		chk("cmp_fall", 32'h200, q[9:0]);
		chk("cmp_irq2", 32'h1, cmp_irq);
		bus(1'b1, 5'h10, 32'h300);
	endtask

	// DAC immediate and timer-scheduled updates
	task automatic t_dac;
		bus(1'b1, 5'h14, 32'h60);
		cyc(1);
		chk("dac_sd", 32'h0, dac_shutdown);
		bus(1'b1, 5'h18, 32'habc);
		cyc(1);
		chk("dac0", 32'habc, dac_out[0]);
		bus(1'b1, 5'h1c, 32'h123);
		cyc(2);
		chk("dac1_held", 32'h0, dac_out[1]);
		pulse_tmr(3'b010);
		chk("dac1_wrong", 32'h0, dac_out[1]);
		pulse_tmr(3'b100);
		chk("dac1_upd", 32'h123, dac_out[1]);
	endtask

	task automatic give_verdict;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		cyc(20);
		rst_n <= 1'b1;
		cyc(2);
		t_reset();
		t_conv_sw();
		t_busy();
		t_sources();
		t_cmp();
		t_dac();
		give_verdict();
	end

	// Watchdog against a hung handshake
	initial
	begin
		cyc(5000);
		n_fail++;
		give_verdict();
	end
endmodule
